// >>> include/pidls_pkg.sv
// package: constants and types of the pid loop setup block
`default_nettype none
package pidls_pkg;
  localparam int NLOOP = 2;
  localparam int LVL_W = 17;
  localparam int SNS_W = 16;
  localparam int NV_W = 21;
  // level counts are thousandths of a percent
  localparam logic [16:0] FULL_SCALE = 17'h186A0;
  localparam logic [16:0] ANA_STEP = 17'h00003;
  localparam logic [13:0] P_MAX = 14'h2710;
  localparam logic [13:0] P_RST = 14'h01F4;
  localparam logic [13:0] I_MAX = 14'h2710;
  localparam logic [13:0] I_RST = 14'h00C8;
  localparam logic [7:0] D_MAX = 8'hC8;
  localparam logic [7:0] D_RST = 8'h00;
  localparam logic [16:0] MOUT_RST = 17'h00000;
  localparam logic [15:0] SETPT_RST = 16'h0000;
  localparam logic [1:0] CURVE_RST = 2'h0;
  localparam logic [1:0] UNIT_K = 2'h0;
  localparam logic [1:0] UNIT_C = 2'h1;
  localparam logic [1:0] UNIT_SENS = 2'h2;
  localparam logic [1:0] RNG_OFF = 2'h0;
  // byte offsets inside a loop window; bit 5 picks the loop
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_P = 5'h04;
  localparam logic [4:0] REG_I = 5'h08;
  localparam logic [4:0] REG_D = 5'h0C;
  localparam logic [4:0] REG_MOUT = 5'h10;
  localparam logic [4:0] REG_SETPT = 5'h14;
  localparam logic [4:0] REG_OUT = 5'h18;
  localparam logic [4:0] REG_STAT = 5'h1C;
  localparam logic [7:0] REG_CURVE = 8'h40;
  // control word fields
  localparam int CB_INSEL = 0;
  localparam int CB_OPEN = 1;
  localparam int CB_UNIT = 2;
  localparam int CB_PWRUP = 4;
  localparam int CB_POWER = 5;
  localparam int CB_RANGE = 6;
  localparam int CB_BIPOLAR = 8;
  localparam logic [8:0] CTRL_RST = 9'h008;
  localparam logic [8:0] CTRL_WMASK1 = 9'h0FF;
  localparam logic [8:0] CTRL_WMASK2 = 9'h1DF;
  // retained word: {restore, open, range, offset}
  localparam int NV_PWR = 20;
  localparam int NV_OPEN = 19;
  localparam int NV_RANGE = 17;
  // arithmetic scale: gain and integral in tenths, update rate in hertz
  localparam int SAMPLE_HZ = 10;
  localparam int ITIME_NUM = 10000;
  localparam int DTIME_NUM = 25;
  localparam logic signed [47:0] P_SCALE = 48'sh00000000000A;
  localparam logic signed [47:0] INTEG_DIV = 48'(ITIME_NUM * SAMPLE_HZ);
  localparam logic signed [47:0] DERIV_K = 48'(DTIME_NUM * SAMPLE_HZ);
  typedef enum {RS_REQ, RS_LOAD, RS_RUN} pidls_rs_t;
endpackage
`default_nettype wire

// >>> testbench/pidls_sensor_model.sv
// partner model: sensor readings and sample strobe feeding the control loops
`timescale 1ns/10ps
`default_nettype none
module pidls_sensor_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic slow,
  input wire logic [pidls_pkg::SNS_W-1:0] val_a,
  input wire logic [pidls_pkg::SNS_W-1:0] val_b,
  output logic [pidls_pkg::SNS_W-1:0] sensor_a,
  output logic [pidls_pkg::SNS_W-1:0] sensor_b,
  output logic sample
);
  import pidls_pkg::*;
  logic pend = 1'b0;
  logic [1:0] hold = 2'h0;
  // readings are continuous, so they never go idle between strobes
  assign sensor_a = val_a;
  assign sensor_b = val_b;
  initial sample = 1'b0;
  // slow mode holds the strobe back three cycles, like a late converter
  always @(posedge clk) begin
    sample <= 1'b0;
    if (fire) begin
      pend <= 1'b1;
      hold <= slow ? 2'h3 : 2'h0;
    end else if (pend && hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else if (pend) begin
      pend <= 1'b0;
      sample <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/pidls_top_test.sv
// self-checking testbench of the control loop setup block
`timescale 1ns/10ps
`default_nettype none
module pidls_top_test;
  import pidls_pkg::*;
  logic mclk, rst_b, hsel, hwrite, hreadyout, hresp, htr_is_power, ana_bipolar;
  logic fire, slow, sample;
  logic [31:0] haddr, hwdata, hrdata, rd, cw;
  logic [1:0] htrans, htr_range;
  logic [2:0] hsize;
  logic [15:0] val_a, val_b, sens_a, sens_b;
  logic [16:0] htr_level, ana_level;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 32'h75CA;
  int i, m, e, sp, fb, sel;

  pidls_top u_dut (.MCLK(mclk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .SENSOR_A(sens_a), .SENSOR_B(sens_b),
    .SAMPLE(sample), .HTR_LEVEL(htr_level), .HTR_RANGE(htr_range),
    .HTR_IS_POWER(htr_is_power), .ANA_LEVEL(ana_level), .ANA_BIPOLAR(ana_bipolar));

  pidls_sensor_model u_sns (.clk(mclk), .fire(fire), .slow(slow), .val_a(val_a),
    .val_b(val_b), .sensor_a(sens_a), .sensor_b(sens_b), .sample(sample));

  // ****
  // clock, timeout and verdict
  // ****
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic end_sim;
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // whole run needs about five hundred cycles; a hung handshake stops here
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ****
  // bus and compare tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // entered just after a rising edge; holds each phase until hready is high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h00000000);
    chk(nm, ex, rd);
    chk("hresp", 32'h00000000, 32'(hresp));
  endtask

  task automatic do_reset;
    rst_b <= 1'b0;
    cyc(4);
    rst_b <= 1'b1;
    cyc(12);
  endtask

  // request one strobe, then wait for it and the two-edge update
  task automatic strobe;
    fire <= 1'b1;
    cyc(1);
    fire <= 1'b0;
    while (sample !== 1'b1) cyc(1);
    cyc(3);
  endtask

  function automatic logic [7:0] ra(input int l, input logic [4:0] off);
    return 8'(l * 32) | {3'h0, off};
  endfunction

  function automatic logic [31:0] exp_lvl(input int p, input int s, input int f, input int mo);
    int t;
    t = mo + (p * (s - f)) / 10;
    if (t < 0) t = 0;
    if (t > 100000) t = 100000;
    return 32'(t);
  endfunction

  // ****
  // scenarios
  // ****
  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h00000000;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    fire = 1'b0;
    slow = 1'b0;
    val_a = 16'h0000;
    val_b = 16'h0000;
    do_reset();
    for (i = 0; i < 2; i++) begin
      rdchk("ctrl", ra(i, REG_CTRL), 32'(CTRL_RST) | 32'(i));
      rdchk("p", ra(i, REG_P), 32'(P_RST));
      rdchk("i", ra(i, REG_I), 32'(I_RST));
      rdchk("d", ra(i, REG_D), 32'(D_RST));
      rdchk("mout", ra(i, REG_MOUT), 32'h00000000);
    end
    chk("htr_range", 32'h0, 32'(htr_range));
    chk("ana_level", 32'h0, 32'(ana_level));
    wr(REG_P, 32'h00002711);
    rdchk("p max", REG_P, 32'(P_MAX));
    wr(REG_I, 32'h00002711);
    rdchk("i max", REG_I, 32'(I_MAX));
    wr(REG_D, 32'h000000C9);
    rdchk("d max", REG_D, 32'(D_MAX));
    wr(REG_MOUT, 32'h000186A1);
    rdchk("mout max", REG_MOUT, 32'(FULL_SCALE));
    wr(REG_CTRL, 32'h00000000);
    rdchk("unit no curve", REG_CTRL, 32'h00000008);
    for (i = 0; i < 4; i++) begin
      m = {$random(seed)} % 100001;
      val_a <= 16'($random(seed));
      cw = 32'h0000000A | 32'((1 + i % 3) << CB_RANGE) | 32'((i % 2) << CB_POWER);
      wr(ra(0, REG_CTRL), cw);
      wr(ra(0, REG_MOUT), 32'(m));
      cyc(4);
      chk("htr_level", 32'(m), 32'(htr_level));
      chk("htr_range", 32'(1 + i % 3), 32'(htr_range));
      chk("htr_is_power", 32'(i % 2), 32'(htr_is_power));
      rdchk("out1", ra(0, REG_OUT), 32'(m));
      val_a <= ~val_a;
      cyc(4);
      chk("htr_level held", 32'(m), 32'(htr_level));
      cw = 32'h0000006B | 32'((i % 2) << CB_BIPOLAR);
      wr(ra(1, REG_CTRL), cw);
      rdchk("ctrl2", ra(1, REG_CTRL), cw & 32'h000001DF);
      wr(ra(1, REG_MOUT), 32'(m));
      cyc(4);
      chk("ana_level", 32'((m / 3) * 3), 32'(ana_level));
      chk("ana_bipolar", 32'(i % 2), 32'(ana_bipolar));
      rdchk("out2", ra(1, REG_OUT), 32'((m / 3) * 3));
    end
    wr(ra(0, REG_CTRL), 32'h0000000A);
    cyc(4);
    chk("range off", 32'h0, 32'(htr_level));
    wr(REG_CURVE, 32'h00000003);
    wr(REG_P, 32'h000001F4);
    wr(REG_I, 32'h00000000);
    wr(REG_D, 32'h00000000);
    rdchk("stat", ra(0, REG_STAT), 32'h00000009);
    for (i = 0; i < 8; i++) begin
      sel = i % 2;
      slow <= i[0];
      sp = 16'h4000 + {$random(seed)} % 256;
      e = {$random(seed)} % 2001 - 1000;
      m = {$random(seed)} % 100001;
      if (i == 6) begin
        e = 2000;
        m = 99000;
      end
      if (i == 7) begin
        e = -2000;
        m = 1000;
      end
      fb = sp - e;
      val_a <= sel ? ~16'(fb) : 16'(fb);
      val_b <= sel ? 16'(fb) : ~16'(fb);
      cw = 32'(sel) | 32'((i % 3) << CB_UNIT) | 32'(3 << CB_RANGE);
      wr(ra(0, REG_CTRL), cw);
      // second loop kept on the other input
      wr(ra(1, REG_CTRL), 32'(1 - sel) | 32'h00000002);
      rdchk("ctrl unit", ra(0, REG_CTRL), cw);
      wr(ra(0, REG_SETPT), 32'(sp));
      rdchk("setpt", ra(0, REG_SETPT), 32'(sp));
      wr(ra(0, REG_MOUT), 32'(m));
      strobe();
      chk("closed level", exp_lvl(500, sp, fb, m), 32'(htr_level));
    end
    wr(REG_I, 32'h000000C8);
    rdchk("stat i on", ra(0, REG_STAT), 32'h00000005);
    wr(REG_CURVE, 32'h00000000);
    rdchk("unit lost", ra(0, REG_CTRL), 32'h000000C9);
    wr(ra(0, REG_CTRL), 32'h000000BA);
    wr(ra(0, REG_MOUT), 32'h00003039);
    wr(ra(1, REG_CTRL), 32'h0000004B);
    wr(ra(1, REG_MOUT), 32'h0000012C);
    cyc(2);
    do_reset();
    chk("restored level", 32'h00003039, 32'(htr_level));
    chk("restored range", 32'h2, 32'(htr_range));
    chk("loop2 off", 32'h0, 32'(ana_level));
    wr(ra(0, REG_CTRL), 32'h000000AA);
    cyc(2);
    do_reset();
    chk("heater off", 32'h0, 32'(htr_range));
    chk("heater level", 32'h0, 32'(htr_level));
    end_sim();
  end
endmodule
`default_nettype wire

// >>> verilog/pidls_nvram.sv
// retained storage of each loop's output state across resets
`timescale 1ns/10ps
`default_nettype none
module pidls_nvram #(
  parameter int W = 21,
  parameter int D = 2,
  parameter int AW = 1
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  // no reset: contents must survive the power-up reset
  logic [W-1:0] mem [D];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// >>> verilog/pidls_pid_core.sv
// pid arithmetic of one control loop
`timescale 1ns/10ps
`default_nettype none
module pidls_pid_core (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sample,
  input wire logic open_loop,
  input wire logic run,
  input wire logic [pidls_pkg::SNS_W-1:0] feedback,
  input wire logic [pidls_pkg::SNS_W-1:0] setpoint,
  input wire logic [13:0] p_set,
  input wire logic [13:0] i_set,
  input wire logic [7:0] d_set,
  input wire logic [pidls_pkg::LVL_W-1:0] mout,
  output logic [pidls_pkg::LVL_W-1:0] level
);
  import pidls_pkg::*;
  logic signed [47:0] integ;
  logic signed [16:0] err_prev;
  wire logic signed [16:0] err = $signed({1'b0, setpoint}) - $signed({1'b0, feedback});
  wire logic signed [47:0] p_s = 48'($signed({1'b0, p_set}));
  wire logic signed [47:0] i_s = 48'($signed({1'b0, i_set}));
  wire logic signed [47:0] d_s = 48'($signed({1'b0, d_set}));
  wire logic signed [47:0] full_s = 48'($signed({1'b0, FULL_SCALE}));
  wire logic i_on = (i_set != 14'h0000);
  wire logic signed [47:0] p_err = 48'(err) * p_s / P_SCALE;
  wire logic signed [47:0] p_derr = (48'(err) - 48'(err_prev)) * p_s / P_SCALE;
  // integral time is 1000 / setting seconds
  wire logic signed [47:0] i_term = i_on ? integ / INTEG_DIV : 48'sh0;
  // derivative time scales with integral time; off with it
  wire logic signed [47:0] d_term = i_on ? p_derr * DERIV_K * d_s / i_s : 48'sh0;
  wire logic signed [47:0] sum = 48'($signed({1'b0, mout})) + p_err + i_term + d_term;
  wire logic [16:0] clamped = (sum < 48'sh0) ? 17'h00000 :
    (sum > full_s) ? FULL_SCALE : sum[16:0];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      integ <= 48'sh0;
      err_prev <= 17'sh00000;
      level <= 17'h00000;
    end else if (!run) begin
      integ <= 48'sh0;
      err_prev <= err;
      level <= 17'h00000;
    end else if (open_loop) begin
      // feedback ignored; offset alone drives the load
      integ <= 48'sh0;
      err_prev <= err;
      level <= mout;
    end else if (sample) begin
      // no windup guard: a long saturation needs a gain review
      integ <= i_on ? integ + p_err * i_s : 48'sh0;
      err_prev <= err;
      level <= clamped;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/pidls_top.sv
// control loop setup registers, output computation and bus slave
`timescale 1ns/10ps
`default_nettype none
module pidls_top (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [pidls_pkg::SNS_W-1:0] SENSOR_A,
  input wire logic [pidls_pkg::SNS_W-1:0] SENSOR_B,
  input wire logic SAMPLE,
  output logic [pidls_pkg::LVL_W-1:0] HTR_LEVEL,
  output logic [1:0] HTR_RANGE,
  output logic HTR_IS_POWER,
  output logic [pidls_pkg::LVL_W-1:0] ANA_LEVEL,
  output logic ANA_BIPOLAR
);
  import pidls_pkg::*;

  // ********************************
  // state
  // ********************************
  logic dp_act;
  logic dp_wr;
  logic [7:0] dp_addr;
  pidls_rs_t rs_state;
  logic rs_idx;
  logic nv_we;
  logic nv_idx;
  logic [NV_W-1:0] nv_rd;
  logic [1:0] curve_ok;
  logic [8:0] ctrl [NLOOP];
  logic [13:0] p_set [NLOOP];
  logic [13:0] i_set [NLOOP];
  logic [7:0] d_set [NLOOP];
  logic [16:0] mout [NLOOP];
  logic [15:0] setpt [NLOOP];
  logic [16:0] level [NLOOP];
  logic [31:0] rdata;

  // ********************************
  // bus decode
  // ********************************
  wire logic run = (rs_state == RS_RUN);
  wire logic acc = HSEL && HTRANS[1] && HREADY;
  // a data phase waits out the restore sequence
  wire logic do_op = dp_act && run;
  wire logic wr = do_op && dp_wr;
  wire logic in_loop = (dp_addr[7:6] == 2'h0);
  wire logic rl = dp_addr[5];
  wire logic [4:0] ra = dp_addr[4:0];
  wire logic curve_hit = wr && (dp_addr == REG_CURVE);
  wire logic nv_hit = wr && in_loop && (ra == REG_CTRL || ra == REG_MOUT);
  wire logic [16:0] ana_q = level[1] - (level[1] % ANA_STEP);

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      dp_act <= 1'b0;
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      HREADYOUT <= 1'b1;
      HRDATA <= 32'h00000000;
      HRESP <= 1'b0;
    end else if (acc) begin
      dp_act <= 1'b1;
      dp_wr <= HWRITE;
      dp_addr <= HADDR[7:0];
      HREADYOUT <= 1'b0;
    end else if (do_op) begin
      dp_act <= 1'b0;
      HREADYOUT <= 1'b1;
      HRDATA <= rdata;
    end
  end

  // ********************************
  // power-up restore
  // ********************************
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      rs_state <= RS_REQ;
      rs_idx <= 1'b0;
    end else begin
      unique case (rs_state)
        RS_REQ: begin
          rs_state <= RS_LOAD;
        end
        RS_LOAD: begin
          if (rs_idx == 1'(NLOOP - 1)) begin
            rs_state <= RS_RUN;
          end else begin
            rs_idx <= rs_idx + 1'b1;
            rs_state <= RS_REQ;
          end
        end
        RS_RUN: begin
        end
      endcase
    end
  end

  // retained copy follows every control or offset write
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      nv_we <= 1'b0;
      nv_idx <= 1'b0;
    end else begin
      nv_we <= nv_hit;
      nv_idx <= rl;
    end
  end

  pidls_nvram #(.W(NV_W), .D(NLOOP), .AW(1)) u_nvram (
    .clk(MCLK),
    .we(nv_we),
    .waddr(nv_idx),
    .wdata({ctrl[nv_idx][CB_PWRUP], ctrl[nv_idx][CB_OPEN],
      ctrl[nv_idx][CB_RANGE+:2], mout[nv_idx]}),
    .raddr(rs_idx),
    .rdata(nv_rd)
  );

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      curve_ok <= CURVE_RST;
    end else if (curve_hit) begin
      curve_ok <= HWDATA[1:0];
    end
  end

  // ********************************
  // per-loop settings
  // ********************************
  for (genvar l = 0; l < NLOOP; l++) begin : g_loop
    wire logic hit = wr && in_loop && (rl == 1'(l));
    wire logic ld = (rs_state == RS_LOAD) && (rs_idx == 1'(l));
    wire logic [8:0] wc = HWDATA[8:0] & ((l == 0) ? CTRL_WMASK1 : CTRL_WMASK2);
    wire logic [1:0] wu = wc[CB_UNIT+:2];
    wire logic wtemp = (wu == UNIT_K) || (wu == UNIT_C);
    wire logic [1:0] nu = (wtemp && curve_ok[wc[CB_INSEL]]) ? wu : UNIT_SENS;
    wire logic [8:0] next_ctrl = {wc[8:4], nu, wc[1:0]};
    wire logic unit_ok = curve_ok[ctrl[l][CB_INSEL]];
    // feedback pick per loop; two loops on one input is allowed
    wire logic [15:0] fb = ctrl[l][CB_INSEL] ? SENSOR_B : SENSOR_A;
    wire logic on = (ctrl[l][CB_RANGE+:2] != RNG_OFF);

    always_ff @(posedge MCLK) begin
      if (!RST_B) begin
        // heater off unless the retained state says otherwise
        ctrl[l] <= {CTRL_RST[8:1], 1'(l)};
        p_set[l] <= P_RST;
        i_set[l] <= I_RST;
        d_set[l] <= D_RST;
        mout[l] <= MOUT_RST;
        setpt[l] <= SETPT_RST;
      end else if (ld) begin
        if (nv_rd[NV_PWR]) begin
          ctrl[l][CB_PWRUP] <= 1'b1;
          ctrl[l][CB_OPEN] <= nv_rd[NV_OPEN];
          ctrl[l][CB_RANGE+:2] <= nv_rd[NV_RANGE+:2];
          mout[l] <= nv_rd[16:0];
        end
      end else if (hit) begin
        unique case (ra)
          REG_CTRL: ctrl[l] <= next_ctrl;
          REG_P: p_set[l] <= (HWDATA > 32'(P_MAX)) ? P_MAX : HWDATA[13:0];
          REG_I: i_set[l] <= (HWDATA > 32'(I_MAX)) ? I_MAX : HWDATA[13:0];
          REG_D: d_set[l] <= (HWDATA > 32'(D_MAX)) ? D_MAX : HWDATA[7:0];
          // one entry path: panel and remote both write here
          REG_MOUT: mout[l] <= (HWDATA > 32'(FULL_SCALE)) ? FULL_SCALE : HWDATA[16:0];
          REG_SETPT: setpt[l] <= HWDATA[15:0];
          default: begin
          end
        endcase
      end else if (!unit_ok) begin
        ctrl[l][CB_UNIT+:2] <= UNIT_SENS;
      end
    end

    // unit select is display only and never reaches the core
    pidls_pid_core u_core (
      .clk(MCLK),
      .rst_b(RST_B),
      .sample(SAMPLE),
      .open_loop(ctrl[l][CB_OPEN]),
      .run(on && run),
      .feedback(fb),
      .setpoint(setpt[l]),
      .p_set(p_set[l]),
      .i_set(i_set[l]),
      .d_set(d_set[l]),
      .mout(mout[l]),
      .level(level[l])
    );
  end

  // ********************************
  // read mux
  // ********************************
  wire logic [16:0] out_rep = rl ? ana_q : level[0];
  wire logic [31:0] stat_w = {28'h0000000, ctrl[rl][CB_OPEN],
    (i_set[rl] != 14'h0000), ctrl[rl][CB_POWER], curve_ok[ctrl[rl][CB_INSEL]]};

  always_comb begin
    rdata = 32'h00000000;
    if (dp_addr == REG_CURVE) begin
      rdata = {30'h00000000, curve_ok};
    end else if (in_loop) begin
      unique case (ra)
        REG_CTRL: rdata = {23'h000000, ctrl[rl]};
        REG_P: rdata = {18'h00000, p_set[rl]};
        REG_I: rdata = {18'h00000, i_set[rl]};
        REG_D: rdata = {24'h000000, d_set[rl]};
        REG_MOUT: rdata = {15'h0000, mout[rl]};
        REG_SETPT: rdata = {16'h0000, setpt[rl]};
        REG_OUT: rdata = {15'h0000, out_rep};
        REG_STAT: rdata = stat_w;
        default: rdata = 32'h00000000;
      endcase
    end
  end

  // ********************************
  // output flops
  // ********************************
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      HTR_LEVEL <= 17'h00000;
      HTR_RANGE <= RNG_OFF;
      HTR_IS_POWER <= 1'b0;
      ANA_LEVEL <= 17'h00000;
      ANA_BIPOLAR <= 1'b0;
    end else begin
      HTR_LEVEL <= level[0];
      HTR_RANGE <= ctrl[0][CB_RANGE+:2];
      HTR_IS_POWER <= ctrl[0][CB_POWER];
      ANA_LEVEL <= ana_q;
      ANA_BIPOLAR <= ctrl[1][CB_BIPOLAR];
    end
  end

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  open_drive_a: assert property (
    run && ctrl[0][CB_OPEN] && ctrl[0][CB_RANGE+:2] != RNG_OFF
      |-> ##2 HTR_LEVEL == $past(mout[0], 2))
    else $error("open loop heater level not equal to manual offset");

  heater_off_a: assert property (
    ctrl[0][CB_RANGE+:2] == RNG_OFF |-> ##2 HTR_LEVEL == 17'h00000)
    else $error("heater drives while range is off");

  ana_step_a: assert property (
    (ANA_LEVEL % ANA_STEP) == 17'h00000)
    else $error("analog level not on its step");

  out_clamp_a: assert property (
    HTR_LEVEL <= FULL_SCALE && ANA_LEVEL <= FULL_SCALE)
    else $error("output above full scale");

  unit_fall_a: assert property (
    !curve_ok[ctrl[0][CB_INSEL]] && !wr |=> ctrl[0][CB_UNIT+:2] == UNIT_SENS)
    else $error("temperature units kept without a curve");

  gain_sat_a: assert property (
    wr && dp_addr == {3'h0, REG_P} && HWDATA > 32'(P_MAX) |=> p_set[0] == P_MAX)
    else $error("gain not limited to its maximum");

  mout_sat_a: assert property (
    wr && dp_addr == {3'h0, REG_MOUT} && HWDATA > 32'(FULL_SCALE)
      |=> mout[0] == FULL_SCALE)
    else $error("manual offset not limited to full scale");

  loop2_scale_a: assert property (
    ctrl[1][CB_POWER] == 1'b0 ##1 1'b1 |-> ctrl[1][CB_POWER] == 1'b0)
    else $error("loop 2 gained a power scale");

  restore_a: assert property (
    rs_state == RS_LOAD && rs_idx == 1'b0 && nv_rd[NV_PWR]
      |=> mout[0] == $past(nv_rd[16:0]) && ctrl[0][CB_PWRUP])
    else $error("retained output state not restored");

  // a wait during restore is legal; only a running slave must answer
  bus_wait_a: assert property (
    acc |=> !HREADYOUT ##1 (HREADYOUT || !$past(run)))
    else $error("bus answer timing broken");

  integ_sat_a: assert property (
    wr && dp_addr == {3'h0, REG_I} && HWDATA > 32'(I_MAX) |=> i_set[0] == I_MAX)
    else $error("integral not limited to its maximum");

  deriv_sat_a: assert property (
    wr && dp_addr == {3'h0, REG_D} && HWDATA > 32'(D_MAX) |=> d_set[0] == D_MAX)
    else $error("derivative not limited to its maximum");

  // outputs mirror their source one edge later
  range_out_a: assert property (
    1'b1 |=> HTR_RANGE == $past(ctrl[0][CB_RANGE+:2]))
    else $error("heater range output does not follow its setting");

  scale_out_a: assert property (
    1'b1 |=> HTR_IS_POWER == $past(ctrl[0][CB_POWER]))
    else $error("heater scale output does not follow its setting");

  ana_track_a: assert property (
    1'b1 |=> ANA_LEVEL <= $past(level[1])
      && $past(level[1]) - ANA_LEVEL < ANA_STEP)
    else $error("analog level not the nearest lower step");

  restore_off_a: assert property (
    rs_state == RS_LOAD && rs_idx == 1'b0 && !nv_rd[NV_PWR]
      |=> ctrl[0][CB_RANGE+:2] == RNG_OFF)
    else $error("heater range on after power up without restore");

  integ_off_a: assert property (
    SAMPLE && i_set[0] == 14'h0000 |=> g_loop[0].u_core.integ == 48'sh0)
    else $error("integral kept while its setting is zero");

  okay_resp_a: assert property (
    HRESP == 1'b0)
    else $error("bus response not okay");

  open_cov_c: cover property (run && ctrl[0][CB_OPEN] && HTR_LEVEL != 17'h00000);
  closed_cov_c: cover property (SAMPLE && !ctrl[1][CB_OPEN] && ANA_LEVEL != 17'h00000);
  restore_cov_c: cover property (rs_state == RS_LOAD && nv_rd[NV_PWR]);
  // saturation and a lost curve are the hazards worth seeing
  clamp_cov_c: cover property (SAMPLE && !ctrl[0][CB_OPEN] && level[0] == FULL_SCALE);
  unit_drop_cov_c: cover property (curve_hit && ctrl[0][CB_UNIT+:2] != UNIT_SENS);
endmodule
`default_nettype wire
